// File: src/regfile_pkg.sv
// regfile_pkg: constants and helpers for the banked data register file
// assumes a single core clock domain; no other package is needed
package regfile_pkg;

  // data and address widths
  localparam int DATA_W  = 8;
  localparam int FILE_AW = 5;
  localparam int PTR_W   = 6;
  localparam int GPIDX_W = 6;

  // file addresses of the special function locations and of the first general and upper half locations
  localparam logic [4:0] ADDR_INDIRECT   = 5'h00;
  localparam logic [4:0] ADDR_TIMER      = 5'h01;
  localparam logic [4:0] ADDR_PC_LOW     = 5'h02;
  localparam logic [4:0] ADDR_STATUS     = 5'h03;
  localparam logic [4:0] ADDR_POINTER    = 5'h04;
  localparam logic [4:0] ADDR_OSC        = 5'h05;
  localparam logic [4:0] ADDR_PORT       = 5'h06;
  localparam logic [4:0] ADDR_GP_FIRST   = 5'h07;
  localparam logic [4:0] ADDR_UPPER_HALF = 5'h10;

  // location counts
  localparam int SFR_COUNT       = 7;
  localparam int GP_COUNT        = 25;
  localparam int GP_BANKED_COUNT = 16;
  localparam int GP_TOTAL        = GP_COUNT + GP_BANKED_COUNT;

  // pointer register layout
  localparam int         PTR_BANK_BIT      = 5;
  localparam logic [2:0] PTR_ONES_FLAT     = 3'h7;
  localparam logic [1:0] PTR_ONES_BANKED   = 2'h3;
  localparam logic [5:0] PTR_MASK_FLAT     = 6'h1F;
  localparam logic [5:0] PTR_MASK_BANKED   = 6'h3F;

  // values with no documented reset are cleared
  localparam logic [7:0] SFR_RESET = 8'h00;
  localparam logic [5:0] PTR_RESET = 6'h00;
  localparam logic [7:0] NULL_READ = 8'h00;

  // index into the general purpose store: bank 0 first, then bank 1 upper half
  function automatic logic [GPIDX_W-1:0] gp_index(input logic [4:0] low, input logic upperBank);
    logic [4:0] off;
    off = upperBank ? 5'(low - ADDR_UPPER_HALF) : 5'(low - ADDR_GP_FIRST);
    return upperBank ? GPIDX_W'({1'b0, off}) + GPIDX_W'(GP_COUNT) : GPIDX_W'({1'b0, off});
  endfunction

endpackage

// File: src/addr_resolver.sv
// addr_resolver: turns a file field and the pointer into an effective location
// assumes purely combinational use inside the register file
`timescale 1ns/1ps
`default_nettype none
module addr_resolver
  import regfile_pkg::*;
(
  input  wire logic [FILE_AW-1:0] fileField,
  input  wire logic [PTR_W-1:0]   pointer,
  input  wire logic               banked,
  output logic      [FILE_AW-1:0] effLow,
  output logic                    bankOne,
  output logic                    isSelfRef,
  output logic                    isSfr,
  output logic                    upperBank,
  output logic      [GPIDX_W-1:0] gpIdx
);

  // the indirect location takes its address from the pointer
  always_comb begin
    effLow    = (fileField == ADDR_INDIRECT) ? pointer[FILE_AW-1:0] : fileField;
    bankOne   = banked & pointer[PTR_BANK_BIT];
    isSelfRef = (effLow == ADDR_INDIRECT);
    isSfr     = (effLow < ADDR_GP_FIRST);
    upperBank = bankOne & (effLow >= ADDR_UPPER_HALF); // lower half of bank 1 aliases bank 0
    gpIdx     = gp_index(effLow, upperBank);
  end

endmodule
`default_nettype wire

// File: src/gp_memory.sv
// gp_memory: storage for all general purpose byte locations
// assumes one write per cycle and an asynchronous read by index
`timescale 1ns/1ps
`default_nettype none
module gp_memory
  import regfile_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               wrEn,
  input  wire logic [GPIDX_W-1:0] wrIdx,
  input  wire logic [DATA_W-1:0]  wrData,
  input  wire logic [GPIDX_W-1:0] rdIdx,
  output logic      [DATA_W-1:0]  rdData
);

  typedef struct packed {
    logic [GP_TOTAL-1:0][DATA_W-1:0] cells;
  } mem_state_t;

  mem_state_t state_reg;
  mem_state_t state_next;

  // out-of-range indices never occur; guard anyway so no cell is aliased
  always_comb begin
    state_next = state_reg;
    if (wrEn && (wrIdx < GPIDX_W'(GP_TOTAL))) begin
      state_next.cells[wrIdx] = wrData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData = (rdIdx < GPIDX_W'(GP_TOTAL)) ? state_reg.cells[rdIdx] : NULL_READ;

endmodule
`default_nettype wire

// File: src/banked_data_register_file.sv
// banked_data_register_file: data memory of the core, special and general registers
// assumes the execution datapath issues one access per cycle on core_clk
//
// Behaviour
// - flat variant: seven special, twenty-five general locations
// - banked variant adds sixteen locations, bank 1 upper
// - general locations reachable directly or via pointer
// - indirect location redirects to pointer's target register
// - pointer at indirect location reads zero
// - self-pointing indirect write stores nothing
// - pointer low five bits select address in bank
// - flat variant: pointer upper three bits read ones
// - banked: pointer bit five picks bank, 7:6 ones
// - bank 1 lower half aliases bank 0
`timescale 1ns/1ps
`default_nettype none
module banked_data_register_file
  import regfile_pkg::*;
#(
  parameter bit BANKED = 1'b1
)
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               accValid,
  input  wire logic               accWrite,
  input  wire logic [FILE_AW-1:0] accAddr,
  input  wire logic [DATA_W-1:0]  accWrData,
  input  wire logic               flagUpdEn,
  input  wire logic [DATA_W-1:0]  flagUpdVal,
  output logic      [DATA_W-1:0]  rdData,
  output logic                    rdValid,
  output logic      [DATA_W-1:0]  timerCountValue,
  output logic      [DATA_W-1:0]  programCounterLow,
  output logic      [DATA_W-1:0]  processorStatus,
  output logic      [DATA_W-1:0]  fileSelectPointer,
  output logic      [DATA_W-1:0]  oscillatorTrim,
  output logic      [DATA_W-1:0]  pinPortData
);

  typedef struct packed {
    logic [DATA_W-1:0] timer;
    logic [DATA_W-1:0] pcLow;
    logic [DATA_W-1:0] status;
    logic [PTR_W-1:0]  pointer;
    logic [DATA_W-1:0] oscTrim;
    logic [DATA_W-1:0] port;
    logic [DATA_W-1:0] rdData;
    logic              rdValid;
  } rf_state_t;

  rf_state_t state_reg;
  rf_state_t state_next;

  logic [FILE_AW-1:0] effLow;
  logic               bankOne;
  logic               isSelfRef;
  logic               isSfr;
  logic               upperBank;
  logic [GPIDX_W-1:0] gpIdx;
  logic [DATA_W-1:0]  gpRdData;
  logic               gpWrEn;
  logic [DATA_W-1:0]  ptrView;
  logic [PTR_W-1:0]   ptrMask;

  // address resolution shared by reads and writes
  addr_resolver u_resolver (
    .fileField (accAddr),
    .pointer   (state_reg.pointer),
    .banked    (BANKED),
    .effLow    (effLow),
    .bankOne   (bankOne),
    .isSelfRef (isSelfRef),
    .isSfr     (isSfr),
    .upperBank (upperBank),
    .gpIdx     (gpIdx)
  );

  // general storage; index range covers bank 0 and, when banked, bank 1 upper half
  assign gpWrEn = accValid & accWrite & ~isSfr & (BANKED | ~upperBank);

  gp_memory u_mem (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrEn     (gpWrEn),
    .wrIdx    (gpIdx),
    .wrData   (accWrData),
    .rdIdx    (gpIdx),
    .rdData   (gpRdData)
  );

  // unimplemented pointer bits read as ones; the flat variant also drops bit five
  assign ptrMask = BANKED ? PTR_MASK_BANKED : PTR_MASK_FLAT;
  assign ptrView = BANKED ? {PTR_ONES_BANKED, state_reg.pointer}
                          : {PTR_ONES_FLAT, state_reg.pointer[FILE_AW-1:0]};

  // access decode; the self-referencing indirect case neither reads nor stores
  always_comb begin
    state_next         = state_reg;
    state_next.rdValid = accValid & ~accWrite;
    if (accValid && !accWrite) begin
      if (isSelfRef) begin
        state_next.rdData = NULL_READ;
      end else if (isSfr) begin
        case (effLow)
          ADDR_TIMER:  state_next.rdData = state_reg.timer;
          ADDR_PC_LOW: state_next.rdData = state_reg.pcLow;
          ADDR_STATUS: state_next.rdData = state_reg.status;
          ADDR_POINTER: state_next.rdData = ptrView;
          ADDR_OSC:    state_next.rdData = state_reg.oscTrim;
          ADDR_PORT:   state_next.rdData = state_reg.port;
          default:     state_next.rdData = NULL_READ;
        endcase
      end else begin
        state_next.rdData = gpRdData;
      end
    end
    if (accValid && accWrite && !isSelfRef && isSfr) begin
      case (effLow)
        ADDR_TIMER:  state_next.timer   = accWrData;
        ADDR_PC_LOW: state_next.pcLow   = accWrData;
        ADDR_STATUS: state_next.status  = accWrData;
        ADDR_POINTER: state_next.pointer = accWrData[PTR_W-1:0] & ptrMask;
        ADDR_OSC:    state_next.oscTrim = accWrData;
        ADDR_PORT:   state_next.port    = accWrData;
        default:     state_next.timer   = state_reg.timer;
      endcase
    end
    // flag update from the executing instruction lands last, even on a dropped write
    if (flagUpdEn) begin
      state_next.status = flagUpdVal;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.timer   <= SFR_RESET;
      state_reg.pcLow   <= SFR_RESET;
      state_reg.status  <= SFR_RESET;
      state_reg.pointer <= PTR_RESET;
      state_reg.oscTrim <= SFR_RESET;
      state_reg.port    <= SFR_RESET;
      state_reg.rdData  <= NULL_READ;
      state_reg.rdValid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from state
  assign rdData            = state_reg.rdData;
  assign rdValid           = state_reg.rdValid;
  assign timerCountValue   = state_reg.timer;
  assign programCounterLow = state_reg.pcLow;
  assign processorStatus   = state_reg.status;
  assign fileSelectPointer = ptrView;
  assign oscillatorTrim    = state_reg.oscTrim;
  assign pinPortData       = state_reg.port;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic gpAccess;
  assign gpAccess = accValid & ~isSfr;

  chk_flat_range: assert property (!BANKED && gpAccess |-> gpIdx < GPIDX_W'(GP_COUNT))
    else $error("flat variant reached a banked location");

  chk_bank_upper: assert property (BANKED && gpAccess && bankOne && effLow >= ADDR_UPPER_HALF
                                   |-> gpIdx >= GPIDX_W'(GP_COUNT) && gpIdx < GPIDX_W'(GP_TOTAL))
    else $error("bank 1 upper half not mapped to its own storage");

  chk_direct_rdback: assert property ((accValid && accWrite && accAddr >= ADDR_GP_FIRST && !flagUpdEn)
                                      ##1 (accValid && !accWrite && accAddr == $past(accAddr) && $stable(state_reg.pointer))
                                      |=> rdData == $past(accWrData, 2))
    else $error("direct write not read back");

  chk_indirect_target: assert property ((accValid && accWrite && accAddr == ADDR_INDIRECT && !isSfr)
                                        ##1 (accValid && !accWrite && accAddr == effLow && !isSfr
                                             && $stable(state_reg.pointer))
                                        |=> rdValid && rdData == $past(accWrData, 2))
    else $error("indirect write did not land on the pointed register");

  chk_self_read_zero: assert property (accValid && !accWrite && accAddr == ADDR_INDIRECT && isSelfRef
                                       |=> rdValid && rdData == NULL_READ)
    else $error("self-pointing indirect read not zero");

  chk_self_write_none: assert property (accValid && accWrite && isSelfRef && !flagUpdEn
                                        |=> $stable(state_reg.pointer) && $stable(state_reg.status) && !rdValid)
    else $error("self-pointing indirect write changed state");

  chk_pointer_low: assert property (accValid && accAddr == ADDR_INDIRECT |-> effLow == state_reg.pointer[4:0])
    else $error("pointer low bits not used as address");

  // unimplemented pointer bits as the core sees them
  chk_flat_ones: assert property (!BANKED |-> fileSelectPointer[7:5] == PTR_ONES_FLAT)
    else $error("flat pointer upper bits not ones");

  // the flat variant must never form a bank 1 address
  chk_flat_no_bank: assert property (!BANKED |-> !bankOne && !upperBank)
    else $error("flat variant selected bank 1");

  // bank choice follows bit five only in the banked variant
  chk_banked_ones: assert property (BANKED |-> fileSelectPointer[7:6] == PTR_ONES_BANKED
                                    && bankOne == state_reg.pointer[PTR_BANK_BIT])
    else $error("banked pointer bits wrong");

  // a pointer write keeps the five address bits the core gave
  chk_pointer_write: assert property (accValid && accWrite && accAddr == ADDR_POINTER
                                      |=> fileSelectPointer[4:0] == $past(accWrData[4:0]))
    else $error("pointer write lost address bits");

  // special locations live in flip-flops, never in the general store
  chk_sfr_no_store: assert property (isSfr |-> !gpWrEn)
    else $error("special location written into general store");

  // a self-pointing write must not leak into the general store
  chk_self_no_store: assert property (isSelfRef |-> !gpWrEn)
    else $error("self-pointing write reached general store");

  // flags from the executing instruction land even when the write is dropped
  chk_flag_wins: assert property (flagUpdEn |=> processorStatus == $past(flagUpdVal))
    else $error("flag update lost");

  // a read answers on the next edge, and nothing else raises the answer
  chk_read_answer: assert property (accValid && !accWrite |=> rdValid)
    else $error("read not answered");

  chk_no_spurious: assert property (!(accValid && !accWrite) |=> !rdValid)
    else $error("answer without a read");

  // read data stands until the next read so a slow core can still take it
  chk_read_holds: assert property (!(accValid && !accWrite) |=> $stable(rdData))
    else $error("read data moved without a read");

  chk_alias_lower: assert property (gpAccess && bankOne && effLow < ADDR_UPPER_HALF
                                    |-> gpIdx == gp_index(effLow, 1'b0))
    else $error("bank 1 lower half does not alias bank 0");

  chk_direct_field: assert property (accValid && accAddr != ADDR_INDIRECT |-> effLow == accAddr)
    else $error("direct access not taken from file field");

  cov_self_read:   cover property (accValid && !accWrite && isSelfRef);
  cov_upper_write: cover property (accValid && accWrite && upperBank);
  cov_alias_write: cover property (accValid && accWrite && bankOne && !upperBank && !isSfr);
  cov_back_to_back: cover property ((accValid && accWrite) ##1 (accValid && !accWrite));
  cov_flag_update: cover property (accValid && accWrite && isSelfRef && flagUpdEn);

endmodule
`default_nettype wire

// File: verification/core_model.sv
// core_model: stands in for the execution datapath issuing register file accesses
// assumes one core_clk and a register file that answers a read one edge later
`timescale 1ns/1ps
`default_nettype none
module core_model
  import regfile_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rdValid,
  input  wire logic [DATA_W-1:0]  rdData,
  output logic                    accValid,
  output logic                    accWrite,
  output logic      [FILE_AW-1:0] accAddr,
  output logic      [DATA_W-1:0]  accWrData,
  output logic                    flagUpdEn,
  output logic      [DATA_W-1:0]  flagUpdVal,
  output logic                    hung
);
  // idle request lines from time zero
  initial begin
    accValid = 1'b0;
    accWrite = 1'b0;
    accAddr = 5'h00;
    accWrData = 8'h00;
    flagUpdEn = 1'b0;
    flagUpdVal = 8'h00;
    hung = 1'b0;
  end

  // one access: lines move 1 ns after an edge and hold until the taking edge
  task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                        input logic fe, input logic [7:0] fv, output logic [7:0] q);
    int i;
    @(posedge core_clk);
    #1;
    accValid = 1'b1;
    accWrite = wr;
    accAddr = a;
    accWrData = d;
    flagUpdEn = fe;
    flagUpdVal = fv;
    @(posedge core_clk);
    #1;
    accValid = 1'b0;
    flagUpdEn = 1'b0;
    // released lines show the inverse so a stale value never looks valid
    accAddr = ~a;
    accWrData = ~d;
    q = 8'h00;
    hung = !wr;
    // bounded wait for the read answer; the answer stands one cycle from the taking edge
    for (i = 0; i < 4 && hung; i++) begin
      if (rdValid === 1'b1) begin
        q = rdData;
        hung = 1'b0;
      end else begin
        @(posedge core_clk);
        #1;
      end
    end
  endtask

  // write then read on consecutive edges, the tightest spacing the core uses
  task automatic back_to_back(input logic [4:0] wa, input logic [7:0] d,
                              input logic [4:0] ra, output logic [7:0] q);
    @(posedge core_clk);
    #1;
    accValid = 1'b1;
    accWrite = 1'b1;
    accAddr = wa;
    accWrData = d;
    @(posedge core_clk);
    #1;
    accWrite = 1'b0;
    accAddr = ra;
    @(posedge core_clk);
    #1;
    accValid = 1'b0;
    accAddr = ~ra;
    accWrData = ~d;
    hung = (rdValid !== 1'b1);
    q = rdData;
  endtask
endmodule
`default_nettype wire

// File: verification/banked_data_register_file_test.sv
// banked_data_register_file_test: self-checking bench for the banked register file
// assumes core_model as the access source; a flat copy shares its requests
`timescale 1ns/1ps
`default_nettype none
module banked_data_register_file_test;
  import regfile_pkg::*;
  typedef struct packed {logic [4:0] addr; logic [7:0] data;} row_t;
  logic       core_clk;
  logic       rst_n;
  logic       accValid, accWrite, flagUpdEn, rdValid, hung;
  logic [4:0] accAddr;
  logic [7:0] accWrData, flagUpdVal, rdData, q;
  logic [7:0] timerCountValue, programCounterLow, processorStatus;
  logic [7:0] fileSelectPointer, oscillatorTrim, pinPortData;
  logic [7:0] flatRdData, flatPointer;
  logic       flatRdValid;
  int         miscompares, checks_done;
  // direct writes, each read back with the same value
  row_t rows [6] = '{'{5'h07, 8'h55}, '{5'h1F, 8'hC3}, '{5'h01, 8'h3C},
                     '{5'h02, 8'h81}, '{5'h05, 8'h7E}, '{5'h06, 8'h0F}};

  banked_data_register_file #(.BANKED(1'b1)) i_banked_data_register_file (
    .core_clk(core_clk), .rst_n(rst_n), .accValid(accValid), .accWrite(accWrite),
    .accAddr(accAddr), .accWrData(accWrData), .flagUpdEn(flagUpdEn), .flagUpdVal(flagUpdVal),
    .rdData(rdData), .rdValid(rdValid), .timerCountValue(timerCountValue),
    .programCounterLow(programCounterLow), .processorStatus(processorStatus),
    .fileSelectPointer(fileSelectPointer), .oscillatorTrim(oscillatorTrim),
    .pinPortData(pinPortData));

  // flat variant watching the same requests
  banked_data_register_file #(.BANKED(1'b0)) i_banked_data_register_file_flat (
    .core_clk(core_clk), .rst_n(rst_n), .accValid(accValid), .accWrite(accWrite),
    .accAddr(accAddr), .accWrData(accWrData), .flagUpdEn(flagUpdEn), .flagUpdVal(flagUpdVal),
    .rdData(flatRdData), .rdValid(flatRdValid), .timerCountValue(),
    .programCounterLow(), .processorStatus(),
    .fileSelectPointer(flatPointer), .oscillatorTrim(),
    .pinPortData());

  core_model i_core_model (
    .core_clk(core_clk), .rdValid(rdValid), .rdData(rdData), .accValid(accValid),
    .accWrite(accWrite), .accAddr(accAddr), .accWrData(accWrData), .flagUpdEn(flagUpdEn),
    .flagUpdVal(flagUpdVal), .hung(hung));

  // 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_core_model.access(1'b1, a, d, 1'b0, 8'h00, x);
  endtask

  // a read that never answers counts as a mismatch and ends the run
  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    i_core_model.access(1'b0, a, 8'h00, 1'b0, 8'h00, r);
    if (hung !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask

  // write then read on consecutive edges
  task automatic pair(input logic [4:0] wa, input logic [7:0] d, input logic [4:0] ra,
                      output logic [7:0] r);
    i_core_model.back_to_back(wa, d, ra, r);
    if (hung !== 1'b0) begin
      miscompares++;
      stop_test();
    end
  endtask

  // overall watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check("reset pointer", fileSelectPointer, 8'hC0);
    check("flat reset pointer", flatPointer, 8'hE0);
    check("reset status", processorStatus, 8'h00);
    check("reset rdValid", {7'h00, rdValid}, 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      rd(rows[i].addr, q);
      check("direct read", q, rows[i].data);
    end
    $display("test direct table done");
    wr(ADDR_POINTER, 8'hFF);
    check("pointer all", fileSelectPointer, 8'hFF);
    check("flat pointer all", flatPointer, 8'hFF);
    wr(ADDR_POINTER, 8'h1F);
    check("pointer low", fileSelectPointer, 8'hDF);
    check("flat pointer low", flatPointer, 8'hFF);
    $display("test pointer done");
    // bank 1 upper half through the window, then directly with the bank bit set
    wr(ADDR_POINTER, 8'h30);
    check("flat pointer bank", flatPointer, 8'hF0);
    wr(ADDR_INDIRECT, 8'hAA);
    rd(ADDR_INDIRECT, q);
    check("indirect upper", q, 8'hAA);
    check("flat indirect", flatRdData, 8'hAA);
    rd(5'h10, q);
    check("direct banked", q, 8'hAA);
    wr(ADDR_POINTER, 8'h10);
    rd(ADDR_INDIRECT, q);
    check("bank0 distinct", q, 8'h00);
    check("flat no bank", flatRdData, 8'hAA);
    wr(ADDR_POINTER, 8'h27);
    rd(ADDR_INDIRECT, q);
    check("bank1 alias", q, 8'h55);
    $display("test banking done");
    // back to back: the read must see the write of the edge before
    wr(ADDR_POINTER, 8'h0B);
    pair(ADDR_INDIRECT, 8'h69, 5'h0B, q);
    check("pair indirect", q, 8'h69);
    check("flat pair indirect", flatRdData, 8'h69);
    pair(5'h0A, 8'h96, 5'h0A, q);
    check("pair direct", q, 8'h96);
    $display("test back to back done");
    // self-pointing window: reads zero, write lost, flag update kept
    wr(ADDR_POINTER, 8'h00);
    rd(ADDR_INDIRECT, q);
    check("self read", q, 8'h00);
    i_core_model.access(1'b1, ADDR_INDIRECT, 8'h77, 1'b1, 8'h5A, q);
    check("self flags", processorStatus, 8'h5A);
    check("self pointer", fileSelectPointer, 8'hC0);
    check("self timer", timerCountValue, 8'h3C);
    rd(5'h07, q);
    check("self store", q, 8'h55);
    $display("test self pointer done");
    // reset again in mid-run: registers and storage return to their cleared state
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    check("rerun pointer", fileSelectPointer, 8'hC0);
    check("rerun flat pointer", flatPointer, 8'hE0);
    check("rerun timer", timerCountValue, 8'h00);
    check("rerun rdValid", {7'h00, rdValid}, 8'h00);
    rd(5'h07, q);
    check("rerun store", q, 8'h00);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
